/* hdl/psop_consts.vh */
/*
  constants for the pipelined sample output port: widths, stage count,
  latency and code points.
  assumes inclusion by bare name from design files.
*/
`ifndef PSOP_CONSTS_VH
`define PSOP_CONSTS_VH

`define PSOP_DATA_W        10
`define PSOP_STAGES        9
`define PSOP_STAGE_BITS    2
`define PSOP_LATENCY       5
`define PSOP_FIFO_DEPTH    4
`define PSOP_CODE_ZERO     10'h000
`define PSOP_CODE_MID      10'h200
`define PSOP_CODE_3Q       10'h380
`define PSOP_CODE_FULL     10'h3FF
`define PSOP_PH_SAMPLE     2'h1
`define PSOP_PH_HOLD       2'h2

`endif

/* hdl/psop_fifo.v */
/*
  small flip-flop fifo with valid/ready on both sides.
  assumes one clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
module psop_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             ref_clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* hdl/psop_correct.v */
/*
  digital error correction: sums aligned overlapping two-bit stage codes.
  assumes stage codes already time aligned and held for one cycle.
*/
`timescale 1ns/10ps
`include "psop_consts.vh"
module psop_correct #(
  parameter STAGES = 9,
  parameter DATA_W = 10
) (
  input  wire [2*STAGES-1:0] stage_codes,
  output wire [DATA_W-1:0]   corrected
);
  wire [DATA_W+1:0] partial [0:STAGES];

  assign partial[0] = {(DATA_W+2){1'b0}};
  genvar g;
  generate
    for (g = 0; g < STAGES; g = g + 1) begin : g_sum
      // stage g weight 2^(STAGES-1-g), one redundant bit overlaps next
      assign partial[g+1] = partial[g] +
        ({{DATA_W{1'b0}}, stage_codes[2*g+1:2*g]} << (STAGES-1-g));
    end
  endgenerate

  // clamp overflow from redundancy
  assign corrected = (partial[STAGES] > {2'b00, `PSOP_CODE_FULL}) ?
                     `PSOP_CODE_FULL : partial[STAGES][DATA_W-1:0];
endmodule

/* hdl/psop_top.v */
/*
  pipelined sample output port: nine-stage two-bit pipeline, alignment,
  correction, five-cycle latency output with active-low output enable.
  assumes ref_clk is the convert clock, stage codes arrive per stage each
  edge from the analog quantizers, and capture logic consumes each word.
*/
`timescale 1ns/10ps
`include "psop_consts.vh"
module psop_top #(
  parameter DATA_W  = `PSOP_DATA_W,
  parameter STAGES  = `PSOP_STAGES,
  parameter LATENCY = `PSOP_LATENCY,
  parameter DEPTH   = `PSOP_FIFO_DEPTH
) (
  input  wire                ref_clk,
  input  wire                arst_n,
  input  wire [2*STAGES-1:0] stage_codes,
  input  wire                out_en_n,
  input  wire                cap_ready,
  output reg  [DATA_W-1:0]   data_out,
  output reg  [DATA_W-1:0]   data_oe,
  output reg                 data_valid,
  output reg  [1:0]          phase,
  output reg                 in_stall
);
  // startup states, one-hot
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_FLUSH = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;

  wire [2*STAGES-1:0] aligned;
  wire [DATA_W-1:0]   offset_binary_coding;
  reg  [DATA_W-1:0]   corr_q;
  reg                 corr_v;
  reg  [DATA_W-1:0]   lat_q [0:LATENCY-3];
  reg  [LATENCY-3:0]  lat_v;
  reg  [2:0]          start_st;
  reg  [2:0]          next_start_st;
  reg  [3:0]          fill;
  wire                fifo_in_ready;
  wire [DATA_W-1:0]   fifo_data;
  wire                fifo_valid;
  integer             k;

  // nine stages, each code taken on its own edge
  genvar g;
  generate
    for (g = 0; g < STAGES; g = g + 1) begin : g_align
      if (g == STAGES-1) begin : g_last
        // last stage already in step with its sample
        assign aligned[2*g+1:2*g] = stage_codes[2*g+1:2*g];
      end else begin : g_dly
        // own delay line of STAGES-1-g taps
        reg [1:0] tap [0:STAGES-2-g];
        integer   t;
        always @(posedge ref_clk or negedge arst_n) begin
          if (!arst_n) begin
            for (t = 0; t < STAGES-1-g; t = t + 1) begin
              tap[t] <= 2'h0;
            end
          end else begin
            tap[0] <= stage_codes[2*g+1:2*g];
            for (t = 1; t < STAGES-1-g; t = t + 1) begin
              tap[t] <= tap[t-1];
            end
          end
        end
        assign aligned[2*g+1:2*g] = tap[STAGES-2-g];
      end
    end
  endgenerate

  // startup: words stay unmarked until every delay line holds real codes
  always @* begin
    next_start_st = start_st;
    case (start_st)
      ST_IDLE: begin
        next_start_st = ST_FLUSH;
      end
      ST_FLUSH: begin
        if (fill == STAGES[3:0] - 4'h2) begin
          next_start_st = ST_RUN;
        end
      end
      ST_RUN: begin
        next_start_st = ST_RUN;
      end
      default: begin
        next_start_st = ST_IDLE;
      end
    endcase
  end

  // startup state and edge count since reset release, held once in run
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_st <= ST_IDLE;
      fill     <= 4'h0;
    end else begin
      start_st <= next_start_st;
      if (start_st != ST_RUN) begin
        fill <= fill + 4'h1;
      end
    end
  end

  // redundant-bit correction to offset binary
  psop_correct #(
    .STAGES (STAGES),
    .DATA_W (DATA_W)
  ) u_correct (
    .stage_codes (aligned),
    .corrected   (offset_binary_coding)
  );

  // correction register on the edge that takes the last stage
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      corr_q <= `PSOP_CODE_MID;
      corr_v <= 1'b0;
    end else begin
      corr_q <= offset_binary_coding;
      corr_v <= (start_st == ST_RUN);
    end
  end

  // latency taps: corr_q, three taps, fifo write, output register
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (k = 0; k < LATENCY-2; k = k + 1) begin
        lat_q[k] <= `PSOP_CODE_ZERO;
      end
      lat_v <= {(LATENCY-2){1'b0}};
    end else begin
      lat_q[0] <= corr_q;
      lat_v[0] <= corr_v;
      for (k = 1; k < LATENCY-2; k = k + 1) begin
        lat_q[k] <= lat_q[k-1];
        lat_v[k] <= lat_v[k-1];
      end
    end
  end

  // fifo in the data path; fill side stall is exported
  psop_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (2)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_data   (lat_q[LATENCY-3]),
    .in_valid  (lat_v[LATENCY-3]),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (cap_ready)
  );

  // output word, five edges after the last stage edge
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= `PSOP_CODE_ZERO;
    end else if (fifo_valid && cap_ready) begin
      data_out <= fifo_data;
    end
  end

  // one pulse per word handed over
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_valid <= 1'b0;
    end else begin
      data_valid <= fifo_valid & cap_ready;
    end
  end

  // release on high, drive on low
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_oe <= {DATA_W{1'b0}};
    end else begin
      data_oe <= out_en_n ? {DATA_W{1'b0}} : {DATA_W{1'b1}};
    end
  end

  // fifo full; new words are dropped while it stands
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_stall <= 1'b0;
    end else begin
      in_stall <= ~fifo_in_ready;
    end
  end

  // two non-overlapping phases, sample then hold
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
    end else begin
      case (phase)
        2'h0: begin
          phase <= `PSOP_PH_SAMPLE;
        end
        `PSOP_PH_SAMPLE: begin
          phase <= `PSOP_PH_HOLD;
        end
        `PSOP_PH_HOLD: begin
          phase <= `PSOP_PH_SAMPLE;
        end
        default: begin
          phase <= 2'h0;
        end
      endcase
    end
  end
endmodule

/* verification/psop_checker.sv */
/* assertions on the sample output port top.
   assumes one clock, reset async active low. */
`timescale 1ns/10ps
module psop_checker (
  input logic        ref_clk,
  input logic        arst_n,
  input logic [17:0] stage_codes,
  input logic        out_en_n,
  input logic        cap_ready,
  input logic [9:0]  data_out,
  input logic [9:0]  data_oe,
  input logic        data_valid,
  input logic [1:0]  phase,
  input logic        in_stall
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_oe_off; out_en_n |=> data_oe == 10'h000; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus not released");
  property p_oe_on; !out_en_n |=> data_oe == 10'h3FF; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_ph_alt; phase == 2'h1 |=> phase == 2'h2; endproperty
  a_ph_alt: assert property (p_ph_alt) else $error("hold phase missing");
  property p_ph_back; phase == 2'h2 |=> phase == 2'h1; endproperty
  a_ph_back: assert property (p_ph_back) else $error("sample phase missing");
  property p_ph_go; phase == 2'h0 |=> phase == 2'h1; endproperty
  a_ph_go: assert property (p_ph_go) else $error("sub clock not started");
  property p_run; data_valid ##1 cap_ready [*2] |-> data_valid; endproperty
  a_run: assert property (p_run) else $error("word per clock broken");
  property p_quiet; !cap_ready |=> !data_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("word while stalled");
  property p_hold; !data_valid |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("word changed unmarked");
  c_stall: cover property (in_stall);
  c_oe: cover property (out_en_n ##1 !out_en_n);
  c_run: cover property (data_valid [*4]);
endmodule
bind psop_top psop_checker u_chk (.ref_clk, .arst_n, .stage_codes, .out_en_n, .cap_ready,
  .data_out, .data_oe, .data_valid, .phase, .in_stall);

/* verification/psop_capture.sv */
/* capture side model: latches and tags each word.
   assumes words marked by a one-cycle valid pulse. */
`timescale 1ns/10ps
module psop_capture (
  input  logic       ref_clk,
  input  logic       arst_n,
  input  logic [9:0] data_out,
  input  logic       data_valid,
  input  logic       hold_off,
  output logic       cap_ready,
  output logic [9:0] word,
  output int         index,
  output logic       good
);
  // once per clock, first five words invalid, index tag
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_ready <= 1'b0;
      index <= 0;
      word <= 10'h000;
    end else begin
      cap_ready <= !hold_off;
      if (data_valid) begin
        word <= data_out;
        index <= index + 1;
      end
    end
  end
  assign good = index > 5;
endmodule

/* verification/testbench.sv */
/* testbench for the sample output port.
   assumes the capture model and checker beside the top. */
`timescale 1ns/10ps
module testbench;
  logic        ref_clk;
  logic        arst_n;
  logic [17:0] codes;
  logic        oe_n;
  logic        hold;
  logic        cap_ready;
  logic [9:0]  data_out;
  logic [9:0]  data_oe;
  logic        data_valid;
  logic        in_stall;
  wire  [9:0]  bus;
  logic [9:0]  cap_word;
  logic        cap_good;
  int          err_count;
  int          comparisons;
  psop_top dut (.ref_clk, .arst_n, .stage_codes(codes), .out_en_n(oe_n), .cap_ready,
    .data_out, .data_oe, .data_valid, .phase(), .in_stall);
  psop_capture cap (.ref_clk, .arst_n, .data_out, .data_valid, .hold_off(hold), .cap_ready,
    .word(cap_word), .index(), .good(cap_good));
  for (genvar b = 0; b < 10; b++) begin : g_pin
    assign bus[b] = data_oe[b] ? data_out[b] : 1'bz;
  end
  always #50 ref_clk = ~ref_clk;
  task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function logic [9:0] weigh(input logic [17:0] c);
    int s;
    s = 0;
    for (int g = 0; g < 9; g++) s += c[2*g +: 2] << (8 - g);
    return (s > 1023) ? 10'h3FF : 10'(s);
  endfunction
  task t_codes;
    logic [17:0] tbl [5];
    tbl = '{18'h00000, 18'h00002, 18'h10002, 18'h00007, 18'h3FFFF};
    foreach (tbl[i]) begin
      @(posedge ref_clk) codes <= tbl[i];
      repeat (20) @(posedge ref_clk);
      #1;
      chk("word", weigh(tbl[i]), data_out);
      chk("pins", weigh(tbl[i]), bus);
    end
  endtask
  task t_rate;
    int n;
    n = 0;
    repeat (10) begin
      @(posedge ref_clk) #1;
      if (data_valid === 1'b1) n++;
    end
    chk("rate", 10'hA, 10'(n));
    chk("capture", 10'h381, cap_word);
    chk("tagged", 10'h001, {9'h000, cap_good});
  endtask
  task t_skew;
    logic [17:0] tgt;
    tgt = 18'h10007;
    for (int g = 0; g < 9; g++) begin
      @(posedge ref_clk) codes[2*g +: 2] <= tgt[2*g +: 2];
    end
    repeat (5) @(posedge ref_clk);
    #1 chk("early", 10'h3FF, data_out);
    @(posedge ref_clk) #1;
    chk("late", weigh(tgt), data_out);
  endtask
  task t_oe;
    @(posedge ref_clk) oe_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("hiz", {10{1'bz}}, bus);
    @(posedge ref_clk) oe_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("drive", 10'h3FF, data_oe);
  endtask
  task t_stall;
    @(posedge ref_clk) hold <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 chk("full", 10'h001, {9'h000, in_stall});
    chk("quiet", 10'h000, {9'h000, data_valid});
    @(posedge ref_clk) hold <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("drain", 10'h001, {9'h000, data_valid});
  endtask
  initial begin
    #100000;
    err_count++;
    wrap_up;
  end
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    codes = 18'h00000;
    oe_n = 1'b0;
    hold = 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_codes;
    t_skew;
    t_rate;
    t_oe;
    t_stall;
    wrap_up;
  end
endmodule
